// ---- design/irf_top.sv ----
// pending-flag bank of the interrupt controller with processor access port
`timescale 1ns/1ps
module irf_top (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic [31:0] src_req,
   input  wire logic        timer51_request,
   input  wire logic        carrier_timer_output_signal,
   input  wire logic        timer51_carrier_mode,
   input  wire logic        ack_valid,
   input  wire logic [4:0]  ack_src,
   input  wire logic        acc_en,
   input  wire logic [3:0]  acc_kind,
   input  wire logic        acc_write,
   input  wire logic [1:0]  acc_addr,
   input  wire logic [2:0]  acc_bit,
   input  wire logic [15:0] acc_wdata,
   output logic      [15:0] acc_rdata_r,
   output logic      [31:0] pending_r
);
   // ****************************************
   // request sources
   // ****************************************
   logic [31:0] req_all;
   logic        timer51_src;

   // carrier output stands in for the match request in carrier mode
   always_comb begin
      if (timer51_carrier_mode) begin
         timer51_src = carrier_timer_output_signal;
      end else begin
         timer51_src = timer51_request;
      end
   end

   // the timer51 line of the source vector is never used directly
   always_comb begin
      req_all                       = src_req;
      req_all[irf_pkg::TIMER51_BIT] = timer51_src;
   end

   // ****************************************
   // acknowledge decode
   // ****************************************
   logic [31:0] ack_vec;

   always_comb begin
      ack_vec = 32'h0000_0000;
      if (ack_valid) begin
         ack_vec[ack_src] = 1'b1;
      end
   end

   // ****************************************
   // access decode
   // ****************************************
   logic       acc_wr;
   logic       acc_rd;
   logic [3:0] byte_sel;
   logic [3:0] word_sel;
   logic [7:0] bit_mask;

   assign acc_wr = acc_en & acc_write;
   assign acc_rd = acc_en & ~acc_write;

   // one-hot select of the addressed byte register
   always_comb begin
      case (acc_addr)
         irf_pkg::OFF_BANK0_LOW:  byte_sel = 4'h1;
         irf_pkg::OFF_BANK0_HIGH: byte_sel = 4'h2;
         irf_pkg::OFF_BANK1_LOW:  byte_sel = 4'h4;
         irf_pkg::OFF_BANK1_HIGH: byte_sel = 4'h8;
         default:                 byte_sel = 4'h0;
      endcase
   end

   // word access ignores the low address bit
   always_comb begin
      if (acc_addr[1]) begin
         word_sel = 4'hC;
      end else begin
         word_sel = 4'h3;
      end
   end

   always_comb begin
      bit_mask          = 8'h00;
      bit_mask[acc_bit] = 1'b1;
   end

   // ****************************************
   // write steering
   // ****************************************
   logic [3:0] wr_en;
   logic [7:0] wr_mask [irf_pkg::NUM_REGS];
   logic [7:0] wr_data [irf_pkg::NUM_REGS];

   always_comb begin
      for (int i = 0; i < irf_pkg::NUM_REGS; i++) begin
         wr_en[i]   = 1'b0;
         wr_mask[i] = 8'h00;
         wr_data[i] = 8'h00;
      end
      if (acc_wr) begin
         case (acc_kind)
            irf_pkg::ACC_BYTE: begin
               // whole byte replaced, a request in the same cycle still sets its flag
               for (int i = 0; i < irf_pkg::NUM_REGS; i++) begin
                  if (byte_sel[i]) begin
                     wr_en[i]   = 1'b1;
                     wr_mask[i] = 8'hFF;
                     wr_data[i] = acc_wdata[7:0];
                  end
               end
            end
            irf_pkg::ACC_BIT: begin
               // only the chosen flag changes, neighbours kept
               for (int i = 0; i < irf_pkg::NUM_REGS; i++) begin
                  if (byte_sel[i]) begin
                     wr_en[i]   = 1'b1;
                     wr_mask[i] = bit_mask;
                     wr_data[i] = {8{acc_wdata[0]}} & bit_mask;
                  end
               end
            end
            irf_pkg::ACC_WORD: begin
               for (int i = 0; i < irf_pkg::NUM_REGS; i++) begin
                  if (word_sel[i]) begin
                     wr_en[i]   = 1'b1;
                     wr_mask[i] = 8'hFF;
                  end
               end
               // low byte register takes bits 7:0, high byte register bits 15:8
               wr_data[0] = acc_wdata[7:0];
               wr_data[1] = acc_wdata[15:8];
               wr_data[2] = acc_wdata[7:0];
               wr_data[3] = acc_wdata[15:8];
            end
            default: begin
               // no access kind or an invalid one: ignored
               wr_en = 4'h0;
            end
         endcase
      end
   end

   // ****************************************
   // flag registers
   // ****************************************
   logic [7:0]  pending_flags_bank0_low;
   logic [7:0]  pending_flags_bank0_high;
   logic [7:0]  pending_flags_bank1_low;
   logic [7:0]  pending_flags_bank1_high;
   logic [15:0] pending_flags_bank0_word;
   logic [15:0] pending_flags_bank1_word;
   logic [31:0] flags;

   irf_flag_byte u_bank0_low (
      .mclk    (mclk),
      .rst     (rst),
      .hw_set  (req_all[7:0]),
      .ack_clr (ack_vec[7:0]),
      .wr_en   (wr_en[0]),
      .wr_mask (wr_mask[0]),
      .wr_data (wr_data[0]),
      .flags_r (pending_flags_bank0_low)
   );

   irf_flag_byte u_bank0_high (
      .mclk    (mclk),
      .rst     (rst),
      .hw_set  (req_all[15:8]),
      .ack_clr (ack_vec[15:8]),
      .wr_en   (wr_en[1]),
      .wr_mask (wr_mask[1]),
      .wr_data (wr_data[1]),
      .flags_r (pending_flags_bank0_high)
   );

   irf_flag_byte u_bank1_low (
      .mclk    (mclk),
      .rst     (rst),
      .hw_set  (req_all[23:16]),
      .ack_clr (ack_vec[23:16]),
      .wr_en   (wr_en[2]),
      .wr_mask (wr_mask[2]),
      .wr_data (wr_data[2]),
      .flags_r (pending_flags_bank1_low)
   );

   irf_flag_byte u_bank1_high (
      .mclk    (mclk),
      .rst     (rst),
      .hw_set  (req_all[31:24]),
      .ack_clr (ack_vec[31:24]),
      .wr_en   (wr_en[3]),
      .wr_mask (wr_mask[3]),
      .wr_data (wr_data[3]),
      .flags_r (pending_flags_bank1_high)
   );

   // bank pairs as the processor's 16-bit view, high byte on top
   assign pending_flags_bank0_word = {pending_flags_bank0_high, pending_flags_bank0_low};
   assign pending_flags_bank1_word = {pending_flags_bank1_high, pending_flags_bank1_low};
   assign flags                    = {pending_flags_bank1_word, pending_flags_bank0_word};

   // ****************************************
   // read path
   // ****************************************
   logic [7:0]  byte_rd;
   logic        bit_rd;
   logic [15:0] word_rd;
   logic [15:0] acc_rdata_nxt;

   always_comb begin
      case (acc_addr)
         irf_pkg::OFF_BANK0_LOW:  byte_rd = pending_flags_bank0_low;
         irf_pkg::OFF_BANK0_HIGH: byte_rd = pending_flags_bank0_high;
         irf_pkg::OFF_BANK1_LOW:  byte_rd = pending_flags_bank1_low;
         irf_pkg::OFF_BANK1_HIGH: byte_rd = pending_flags_bank1_high;
         default:                 byte_rd = 8'h00;
      endcase
   end

   always_comb begin
      bit_rd = byte_rd[acc_bit];
      if (acc_addr[1]) begin
         word_rd = pending_flags_bank1_word;
      end else begin
         word_rd = pending_flags_bank0_word;
      end
   end

   // read data shows flags as they stood before the access edge
   always_comb begin
      case (acc_kind)
         irf_pkg::ACC_BYTE: acc_rdata_nxt = {8'h00, byte_rd};
         irf_pkg::ACC_BIT:  acc_rdata_nxt = {15'h0, bit_rd};
         irf_pkg::ACC_WORD: acc_rdata_nxt = word_rd;
         default:           acc_rdata_nxt = 16'h0000;
      endcase
   end

   // read data holds until the next read
   always_ff @(posedge mclk) begin
      if (rst) begin
         acc_rdata_r <= {2{irf_pkg::FLAGS_RESET}};
      end else if (acc_rd) begin
         acc_rdata_r <= acc_rdata_nxt;
      end
   end

   // ****************************************
   // pending view
   // ****************************************
   // feeds the arbiter outside; a lower bit has a higher default priority
   always_ff @(posedge mclk) begin
      if (rst) begin
         pending_r <= {irf_pkg::NUM_REGS{irf_pkg::FLAGS_RESET}};
      end else begin
         pending_r <= flags;
      end
   end
endmodule

// ---- design/irf_pkg.sv ----
// package of offsets, field positions and reset values for the request flag bank
package irf_pkg;
   // ****************************************
   // register offsets (byte addresses)
   // ****************************************
   localparam logic [1:0] OFF_BANK0_LOW  = 2'h0;
   localparam logic [1:0] OFF_BANK0_HIGH = 2'h1;
   localparam logic [1:0] OFF_BANK1_LOW  = 2'h2;
   localparam logic [1:0] OFF_BANK1_HIGH = 2'h3;
   // ****************************************
   // layout and reset values
   // ****************************************
   localparam int          NUM_REGS      = 4;
   localparam int          NUM_SRC       = 32;
   localparam logic [7:0]  FLAGS_RESET   = 8'h00;
   localparam int          TIMER51_BIT   = 19;
   // access kinds on the processor port
   typedef enum logic [3:0] {
      ACC_NONE = 4'h1,
      ACC_BYTE = 4'h2,
      ACC_BIT  = 4'h4,
      ACC_WORD = 4'h8
   } irf_acc_t;
endpackage

// ---- design/irf_flag_byte.sv ----
// one 8-bit pending-flag register with a single masked write path shared by byte, bit and word writes
`timescale 1ns/1ps
module irf_flag_byte (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic [7:0] hw_set,
   input  wire logic [7:0] ack_clr,
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_mask,
   input  wire logic [7:0] wr_data,
   output logic      [7:0] flags_r
);
   logic [7:0] flags_nxt;

   always_comb begin
      flags_nxt = flags_r & ~ack_clr;
      if (wr_en) begin
         // written bits replace stored bits, others kept
         flags_nxt = (flags_nxt & ~wr_mask) | (wr_data & wr_mask);
      end
      flags_nxt = flags_nxt | hw_set;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         flags_r <= irf_pkg::FLAGS_RESET;
      end else begin
         flags_r <= flags_nxt;
      end
   end
endmodule

// ---- sim/irf_src_model.sv ----
// request source model: one-cycle pulse on a chosen line
`timescale 1ns/1ps
module irf_src_model (
   input  wire logic        mclk,
   input  wire logic        go,
   input  wire logic [4:0]  idx,
   output logic      [31:0] src_req
);
   initial src_req = 32'h0;
   always @(posedge mclk) src_req <= go ? 32'h1 << idx : 32'h0;
endmodule

// ---- sim/irf_monitor.sv ----
// checker of the pending-flag bank ports
`timescale 1ns/1ps
module irf_monitor (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic [31:0] src_req,
   input wire logic        timer51_request,
   input wire logic        carrier_timer_output_signal,
   input wire logic        timer51_carrier_mode,
   input wire logic        ack_valid,
   input wire logic [4:0]  ack_src,
   input wire logic        acc_en,
   input wire logic [3:0]  acc_kind,
   input wire logic        acc_write,
   input wire logic [1:0]  acc_addr,
   input wire logic [2:0]  acc_bit,
   input wire logic [15:0] acc_wdata,
   input wire logic [15:0] acc_rdata_r,
   input wire logic [31:0] pending_r
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic [31:0] rq;
   logic        wr;
   // timer51 source follows the carrier signal in carrier mode
   always_comb begin
      rq = src_req;
      if (timer51_carrier_mode) begin
         rq[irf_pkg::TIMER51_BIT] = carrier_timer_output_signal;
      end else begin
         rq[irf_pkg::TIMER51_BIT] = timer51_request;
      end
   end
   assign wr = acc_en && acc_write && rq == 32'h0;
   req_sets_a: assert property (rq != 0 |-> ##2 (pending_r & $past(rq, 2)) == $past(rq, 2))
      else $error("request flag not set");
   ack_clr_a: assert property (ack_valid && rq == 0 && !acc_en |-> ##2 !pending_r[$past(ack_src, 2)])
      else $error("ack did not clear");
   byte_wr_a: assert property (wr && acc_kind == irf_pkg::ACC_BYTE |-> ##2
      pending_r[$past(acc_addr, 2) * 8 +: 8] == $past(acc_wdata[7:0], 2)) else $error("byte write");
   bit_wr_a: assert property (wr && acc_kind == irf_pkg::ACC_BIT |-> ##2
      pending_r[{$past(acc_addr, 2), $past(acc_bit, 2)}] == $past(acc_wdata[0], 2)) else $error("bit");
   word_wr_a: assert property (wr && acc_kind == irf_pkg::ACC_WORD |-> ##2
      pending_r[$past(acc_addr[1], 2) * 16 +: 16] == $past(acc_wdata, 2)) else $error("word write");
   byte_rd_a: assert property (acc_en && !acc_write && acc_kind == irf_pkg::ACC_BYTE |=>
      acc_rdata_r == {8'h00, pending_r[$past(acc_addr) * 8 +: 8]}) else $error("byte read");
   rst_clr_a: assert property (disable iff (1'b0) rst |=> pending_r == 32'h0)
      else $error("reset did not clear");
   mode_sel_a: assert property ((timer51_carrier_mode && !acc_en &&
      !carrier_timer_output_signal) ##1 !pending_r[irf_pkg::TIMER51_BIT]
      |=> !pending_r[irf_pkg::TIMER51_BIT])
      else $error("match request set flag in carrier mode");
   cover property (ack_valid);
   cover property (wr && acc_kind == irf_pkg::ACC_WORD);
   cover property (timer51_carrier_mode && carrier_timer_output_signal);
endmodule
bind irf_top irf_monitor u_mon (
   .mclk                        (mclk),
   .rst                         (rst),
   .src_req                     (src_req),
   .timer51_request             (timer51_request),
   .carrier_timer_output_signal (carrier_timer_output_signal),
   .timer51_carrier_mode        (timer51_carrier_mode),
   .ack_valid                   (ack_valid),
   .ack_src                     (ack_src),
   .acc_en                      (acc_en),
   .acc_kind                    (acc_kind),
   .acc_write                   (acc_write),
   .acc_addr                    (acc_addr),
   .acc_bit                     (acc_bit),
   .acc_wdata                   (acc_wdata),
   .acc_rdata_r                 (acc_rdata_r),
   .pending_r                   (pending_r)
);

// ---- sim/test_interrupt_request_flags.sv ----
// self-checking bench of the pending-flag bank
`timescale 1ns/1ps
module test_interrupt_request_flags;
   logic mclk = 0, rst = 1, go = 0, t51 = 0, car = 0, mode = 0, ackv = 0, en = 0, wr = 0;
   logic [4:0] idx = 5'h00, acks = 5'h00;
   logic [3:0] kind = 4'h1;
   logic [1:0] adr = 2'h0;
   logic [2:0] bt = 3'h0;
   logic [15:0] wd = 16'h0000, rd;
   logic [31:0] req, pend;
   int err_total = 0, checks_done = 0;
   irf_src_model u_src (.mclk(mclk), .go(go), .idx(idx), .src_req(req));
   irf_top u_dut (.mclk(mclk), .rst(rst), .src_req(req), .timer51_request(t51),
      .carrier_timer_output_signal(car), .timer51_carrier_mode(mode), .ack_valid(ackv),
      .ack_src(acks), .acc_en(en), .acc_kind(kind), .acc_write(wr), .acc_addr(adr),
      .acc_bit(bt), .acc_wdata(wd), .acc_rdata_r(rd), .pending_r(pend));
   initial forever #20 mclk = ~mclk;
   task step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task chk_pend(input logic [31:0] e);
      checks_done++;
      if (pend !== e) begin
         err_total++;
         $display("MISMATCH pending_r exp %h got %h", e, pend);
      end
   endtask
   task chk_rd(input logic [15:0] e);
      checks_done++;
      if (rd !== e) begin
         err_total++;
         $display("MISMATCH acc_rdata_r exp %h got %h", e, rd);
      end
   endtask
   task acc(input logic [3:0] k, input logic w, input logic [1:0] a, input logic [2:0] b,
            input logic [15:0] d);
      {en, kind, wr, adr, bt, wd} = {1'b1, k, w, a, b, d};
      step(1);
      en = 0;
      step(1);
   endtask
   task fire(input logic [4:0] i);
      {go, idx} = {1'b1, i};
      step(1);
      go = 0;
      step(3);
   endtask
   task s_req;
      chk_pend(32'h0000_0000);
      chk_rd(16'h0000);
      fire(5'h05);
      chk_pend(32'h0000_0020);
      acc(irf_pkg::ACC_BYTE, 1'b0, 2'h0, 3'h0, 16'h0000);
      chk_rd(16'h0020);
      acc(irf_pkg::ACC_BIT, 1'b1, 2'h0, 3'h5, 16'h0000);
      chk_pend(32'h0000_0000);
   endtask
   task s_bank;
      acc(irf_pkg::ACC_BIT, 1'b1, 2'h2, 3'h1, 16'h0001);
      chk_pend(32'h0002_0000);
      acc(irf_pkg::ACC_BIT, 1'b0, 2'h2, 3'h1, 16'h0000);
      chk_rd(16'h0001);
      fire(5'h09);
      chk_pend(32'h0002_0200);
      acc(irf_pkg::ACC_BYTE, 1'b1, 2'h1, 3'h0, 16'h0040);
      chk_pend(32'h0002_4000);
      acc(irf_pkg::ACC_NONE, 1'b1, 2'h1, 3'h0, 16'h00FF);
      chk_pend(32'h0002_4000);
      acc(irf_pkg::ACC_WORD, 1'b1, 2'h2, 3'h0, 16'hA552);
      chk_pend(32'hA552_4000);
      acc(irf_pkg::ACC_WORD, 1'b0, 2'h1, 3'h0, 16'h0000);
      chk_rd(16'h4000);
      acc(irf_pkg::ACC_WORD, 1'b0, 2'h3, 3'h0, 16'h0000);
      chk_rd(16'hA552);
   endtask
   task s_evt;
      {ackv, acks} = {1'b1, 5'h1F};
      step(1);
      ackv = 1'b0;
      step(2);
      chk_pend(32'h2552_4000);
      // match request and acknowledge of the same flag in one cycle
      {t51, ackv, acks} = {1'b1, 1'b1, 5'h13};
      step(1);
      {t51, ackv} = 2'b00;
      step(2);
      chk_pend(32'h255A_4000);
      // noise-set timer flag cleared by one bit before use
      acc(irf_pkg::ACC_BIT, 1'b1, 2'h2, 3'h3, 16'h0000);
      chk_pend(32'h2552_4000);
      {mode, t51} = 2'b11;
      step(1);
      t51 = 1'b0;
      step(2);
      chk_pend(32'h2552_4000);
      car = 1'b1;
      step(1);
      car = 1'b0;
      step(2);
      chk_pend(32'h255A_4000);
      rst = 1'b1;
      step(1);
      rst = 1'b0;
      chk_pend(32'h0000_0000);
      chk_rd(16'h0000);
   endtask
   task end_of_test;
      $display("errors %0d checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      step(2);
      rst = 0;
      s_req;
      s_bank;
      s_evt;
      end_of_test;
   end
endmodule
